//--- hdl/usfc_pkg.sv
// Package with register map, field layout, modes and types of the frame configuration block.
// Summary of operation
// RULE_01: Multiprocessor bit set to 1 turns multiprocessor mode on, 0 turns it off.
// RULE_02: Link-mode selector: 0 async, 1 sync, 2 infrared, 3 host SPI.
// RULE_03: In host SPI mode frame control shows only bit order and clock phase; the code also keeps the two link-mode bits.
// RULE_04: Parity selector: 0 none, 2 even, 3 odd, 1 reserved.
// RULE_05: Stop selector 0 sends one stop bit, 1 sends two.
// RULE_06: Receiver ignores the stop selector; it shapes transmitted frames only.
// RULE_07: Size codes 0 to 3 give 5 to 8 bits, 6 and 7 give 9.
// RULE_08: Code 6 accesses low data byte first, code 7 high byte first.
// RULE_09: SPI bit order 0 sends MSB first, 1 LSB first, both directions.
// RULE_10: Software leaves SPI bit order alone during a transfer.
// RULE_11: SPI clock phase 0 samples leading edge, 1 trailing edge.
// RULE_12: Rate divisor is 16 bits, low byte at base, high byte at base plus one.
// RULE_13: Any divisor write reloads the rate prescaler at once; the link prescaler reloads only after the handshake.
// RULE_14: Software leaves the divisor alone while frames are moving.
// RULE_15: In debug halt the block stops unless debug run is 1.
// RULE_16: Infrared event input is enabled at 0 and disabled at 1.
// RULE_17: Pulse length 0 gives 3/16 bit, 1 to 254 clocks, 255 pass-through; the code ends the length-0 pulse after 2/16 bit.
// RULE_18: Software sets pulse length before enabling the transmitter; infrared mode only.
package usfc_pkg;

  localparam logic [3:0] OFS_MODE_CTRL = 4'h6;
  localparam logic [3:0] OFS_FRAME_CTRL = 4'h7;
  localparam logic [3:0] OFS_RATE_DIV_LO = 4'h8;
  localparam logic [3:0] OFS_RATE_DIV_HI = 4'h9;
  localparam logic [3:0] OFS_DEBUG_CTRL = 4'hb;
  localparam logic [3:0] OFS_EVENT_CTRL = 4'hc;
  localparam logic [3:0] OFS_IR_TX_PULSE = 4'hd;
  localparam logic [3:0] OFS_LINK_STATUS = 4'hf;

  localparam int MULTIPROC_BIT = 0;
  localparam int LINK_MODE_HI = 7;
  localparam int LINK_MODE_LO = 6;
  localparam int PARITY_HI = 5;
  localparam int PARITY_LO = 4;
  localparam int STOP_BIT = 3;
  localparam int SIZE_HI = 2;
  localparam int SIZE_LO = 0;
  localparam int SPI_ORDER_BIT = 2;
  localparam int SPI_PHASE_BIT = 1;
  localparam int DEBUG_RUN_BIT = 0;
  localparam int IR_EVENT_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_RUN_BIT = 1;

  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] FRAME_CTRL_RESET = 8'h03;
  localparam logic [7:0] SPI_FRAME_MASK = 8'hc6;
  localparam logic [15:0] RATE_DIV_RESET = 16'h0000;
  localparam logic [7:0] DEBUG_CTRL_RESET = 8'h00;
  localparam logic [7:0] EVENT_CTRL_RESET = 8'h00;
  localparam logic [7:0] IR_TX_PULSE_RESET = 8'h00;

  localparam logic [7:0] IR_PULSE_FRACTION = 8'h00;
  localparam logic [7:0] IR_PULSE_PASS = 8'hff;
  localparam logic [3:0] IR_LAST_SAMPLE = 4'hf;
  localparam logic [3:0] IR_FRACTION_SAMPLES = 4'h3;

  typedef enum logic [1:0] {
    LINK_ASYNC = 2'b00,
    LINK_SYNC = 2'b01,
    LINK_INFRARED = 2'b10,
    LINK_HOST_SPI = 2'b11
  } usfc_link_mode_type;

  typedef enum logic [1:0] {
    PARITY_NONE = 2'b00,
    PARITY_RSVD = 2'b01,
    PARITY_EVEN = 2'b10,
    PARITY_ODD = 2'b11
  } usfc_parity_type;

  typedef struct packed {
    usfc_link_mode_type link_mode_sel;
    logic multiproc_mode_en;
    logic parity_en;
    logic parity_odd;
    logic parity_reserved;
    logic tx_stop_two;
    logic [3:0] data_bits;
    logic size_reserved;
    logic nine_bit_high_first;
    logic spi_bit_order;
    logic spi_clock_phase;
  } usfc_fmt_type;

  typedef struct packed {
    logic [15:0] rate_div;
    logic [7:0] ir_tx_pulse_len;
    logic infrared_mode;
    logic debug_run;
  } usfc_link_cfg_type;

endpackage

//--- hdl/usfc_cfg_cross.sv
// Toggle handshake that carries the link configuration word into the link clock domain.
`timescale 1ns/1ps
module usfc_cfg_cross (
  // Register side
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire usfc_pkg::usfc_link_cfg_type cfg_in,
  output logic busy,
  // Link side
  input wire logic link_clk,
  output usfc_pkg::usfc_link_cfg_type cfg_out,
  output logic cfg_new
);

  usfc_pkg::usfc_link_cfg_type hold;
  logic req;
  logic pending;
  logic ack_s1;
  logic ack_s2;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic start;

  // A load during a handshake stays pending and is sent with the newest word after it.
  assign start = pending && (req == ack_s2);
  assign busy = pending || (req != ack_s2);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pending <= 1'b0;
      req <= 1'b0;
      hold <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else
    begin
      ack_s1 <= req_s3;
      ack_s2 <= ack_s1;
      if (load)
        pending <= 1'b1;
      else if (start)
        pending <= 1'b0;
      if (start)
      begin
        hold <= cfg_in;
        req <= ~req;
      end
    end
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      cfg_out <= '0;
      cfg_new <= 1'b0;
    end
    else
    begin
      req_s1 <= req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      cfg_new <= req_s2 ^ req_s3;
      if (req_s2 ^ req_s3)
        cfg_out <= hold;
    end
  end

endmodule // usfc_cfg_cross

//--- hdl/usfc_link_rate.sv
// Link-domain rate prescaler with infrared pulse shaping.
`timescale 1ns/1ps
module usfc_link_rate (
  // Clock and reset
  input wire logic link_clk,
  input wire logic arst_n,
  // Configuration
  input wire usfc_pkg::usfc_link_cfg_type cfg,
  input wire logic cfg_new,
  input wire logic debug_halt_ref,
  // Link signals
  input wire logic tx_level,
  output logic rate_tick,
  output logic bit_start,
  output logic ir_tx_out
);

  logic halt_s1;
  logic halt_s2;
  logic stop;
  logic [15:0] count;
  logic [3:0] sample;
  logic [7:0] pulse_left;
  logic pulse_on;

  assign stop = halt_s2 && !cfg.debug_run; // RULE_15

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
    end
    else
    begin
      halt_s1 <= debug_halt_ref;
      halt_s2 <= halt_s1;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= usfc_pkg::RATE_DIV_RESET;
      sample <= '0;
      rate_tick <= 1'b0;
      bit_start <= 1'b0;
    end
    else if (cfg_new)
    begin
      count <= cfg.rate_div; // RULE_13
      sample <= '0;
      rate_tick <= 1'b0;
      bit_start <= 1'b0;
    end
    else
    begin
      rate_tick <= !stop && (count == 16'h0000);
      bit_start <= !stop && (count == 16'h0000) && (sample == 4'h0);
      if (!stop)
      begin
        if (count == 16'h0000)
        begin
          count <= cfg.rate_div;
          sample <= sample + 4'h1;
        end
        else
          count <= count - 16'h0001;
      end
    end
  end

  // Zero bits are sent as pulses; the pulse starts on the bit's first rate tick.
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pulse_left <= '0;
      pulse_on <= 1'b0;
    end
    else if (bit_start && !tx_level)
    begin
      pulse_on <= 1'b1;
      pulse_left <= cfg.ir_tx_pulse_len - 8'h01; // RULE_17
    end
    else if (cfg.ir_tx_pulse_len == usfc_pkg::IR_PULSE_FRACTION)
    begin
      if (rate_tick && sample == usfc_pkg::IR_FRACTION_SAMPLES)
        pulse_on <= 1'b0; // RULE_17
    end
    else if (pulse_on && !stop)
    begin
      if (pulse_left == 8'h00)
        pulse_on <= 1'b0;
      else
        pulse_left <= pulse_left - 8'h01;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      ir_tx_out <= 1'b1;
    else if (!cfg.infrared_mode || cfg.ir_tx_pulse_len == usfc_pkg::IR_PULSE_PASS)
      ir_tx_out <= tx_level; // RULE_18
    else
      ir_tx_out <= !pulse_on;
  end

endmodule // usfc_link_rate

//--- hdl/usfc_frame_config_regs.sv
// Frame configuration registers of the serial transceiver with link-domain rate logic.
`timescale 1ns/1ps
module usfc_frame_config_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // System
  input wire logic debug_halt,
  input wire logic ir_event_in,
  output logic ir_event_out,
  output logic periph_run,
  // Frame format to the shift engines
  output usfc_pkg::usfc_fmt_type fmt,
  output logic [15:0] rate_div_out,
  output logic rate_reload,
  output logic [7:0] ir_tx_pulse_len_out,
  // Link side
  input wire logic link_clk,
  input wire logic tx_level,
  output logic rate_tick,
  output logic bit_start,
  output logic ir_tx_out
);

  logic [7:0] mode_ctrl;
  logic [7:0] frame_ctrl;
  logic [15:0] rate_div;
  logic [7:0] debug_ctrl;
  logic [7:0] event_ctrl;
  logic [7:0] ir_tx_pulse_len;
  logic wr_mode;
  logic wr_frame;
  logic wr_div_lo;
  logic wr_div_hi;
  logic wr_debug;
  logic wr_event;
  logic wr_pulse;
  logic cfg_load;
  logic cross_busy;
  logic [7:0] next_rdata;
  usfc_pkg::usfc_fmt_type next_fmt;
  usfc_pkg::usfc_link_cfg_type link_cfg;
  usfc_pkg::usfc_link_cfg_type link_cfg_sync;
  logic link_cfg_new;

  // Host SPI mode is detected from a frame control byte in three places.
  function automatic logic is_host_spi(input logic [7:0] value);
    is_host_spi = value[usfc_pkg::LINK_MODE_HI:usfc_pkg::LINK_MODE_LO] ==
                  usfc_pkg::LINK_HOST_SPI;
  endfunction

  // Data bit count for a size code; reserved codes fall back to eight bits.
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h3: char_bits = 4'h8;
      3'h6: char_bits = 4'h9;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  assign wr_mode = reg_wr && (reg_addr == usfc_pkg::OFS_MODE_CTRL);
  assign wr_frame = reg_wr && (reg_addr == usfc_pkg::OFS_FRAME_CTRL);
  assign wr_div_lo = reg_wr && (reg_addr == usfc_pkg::OFS_RATE_DIV_LO);
  assign wr_div_hi = reg_wr && (reg_addr == usfc_pkg::OFS_RATE_DIV_HI);
  assign wr_debug = reg_wr && (reg_addr == usfc_pkg::OFS_DEBUG_CTRL);
  assign wr_event = reg_wr && (reg_addr == usfc_pkg::OFS_EVENT_CTRL);
  assign wr_pulse = reg_wr && (reg_addr == usfc_pkg::OFS_IR_TX_PULSE);

  // Every write that touches the link setup starts a new transfer of it.
  assign cfg_load = wr_frame || wr_div_lo || wr_div_hi || wr_debug || wr_pulse;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_ctrl <= usfc_pkg::MODE_CTRL_RESET;
    end
    else if (wr_mode)
    begin
      mode_ctrl <= 8'h00;
      mode_ctrl[usfc_pkg::MULTIPROC_BIT] <= reg_wdata[usfc_pkg::MULTIPROC_BIT]; // RULE_01
    end
  end

  // Writing mode 3 drops the fields that the SPI layout does not hold.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frame_ctrl <= usfc_pkg::FRAME_CTRL_RESET;
    end
    else if (wr_frame)
    begin
      if (is_host_spi(reg_wdata))
      begin
        frame_ctrl <= reg_wdata & usfc_pkg::SPI_FRAME_MASK; // RULE_03
      end
      else
      begin
        frame_ctrl <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rate_div <= usfc_pkg::RATE_DIV_RESET;
    end
    else if (wr_div_lo)
    begin
      rate_div[7:0] <= reg_wdata; // RULE_12
    end
    else if (wr_div_hi)
    begin
      rate_div[15:8] <= reg_wdata; // RULE_12
    end
  end

  // A pulse for the local prescaler on every divisor byte written.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rate_reload <= 1'b0;
    end
    else
    begin
      rate_reload <= wr_div_lo || wr_div_hi; // RULE_13
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      debug_ctrl <= usfc_pkg::DEBUG_CTRL_RESET;
    end
    else if (wr_debug)
    begin
      debug_ctrl <= 8'h00;
      debug_ctrl[usfc_pkg::DEBUG_RUN_BIT] <= reg_wdata[usfc_pkg::DEBUG_RUN_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      event_ctrl <= usfc_pkg::EVENT_CTRL_RESET;
    end
    else if (wr_event)
    begin
      event_ctrl <= 8'h00;
      event_ctrl[usfc_pkg::IR_EVENT_BIT] <= reg_wdata[usfc_pkg::IR_EVENT_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ir_tx_pulse_len <= usfc_pkg::IR_TX_PULSE_RESET;
    end
    else if (wr_pulse)
    begin
      ir_tx_pulse_len <= reg_wdata;
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped addresses read zero.
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        usfc_pkg::OFS_MODE_CTRL: next_rdata = mode_ctrl;
        usfc_pkg::OFS_FRAME_CTRL:
        begin
          if (is_host_spi(frame_ctrl))
            next_rdata = frame_ctrl & usfc_pkg::SPI_FRAME_MASK; // RULE_03
          else
            next_rdata = frame_ctrl;
        end
        usfc_pkg::OFS_RATE_DIV_LO: next_rdata = rate_div[7:0];
        usfc_pkg::OFS_RATE_DIV_HI: next_rdata = rate_div[15:8];
        usfc_pkg::OFS_DEBUG_CTRL: next_rdata = debug_ctrl;
        usfc_pkg::OFS_EVENT_CTRL: next_rdata = event_ctrl;
        usfc_pkg::OFS_IR_TX_PULSE: next_rdata = ir_tx_pulse_len;
        usfc_pkg::OFS_LINK_STATUS:
        begin
          next_rdata[usfc_pkg::STATUS_BUSY_BIT] = cross_busy;
          next_rdata[usfc_pkg::STATUS_RUN_BIT] = periph_run;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // Frame format decode for the shift engines.
  always_comb
  begin
    next_fmt = '0;
    next_fmt.link_mode_sel = usfc_pkg::usfc_link_mode_type'(
      frame_ctrl[usfc_pkg::LINK_MODE_HI:usfc_pkg::LINK_MODE_LO]); // RULE_02
    next_fmt.multiproc_mode_en = mode_ctrl[usfc_pkg::MULTIPROC_BIT]; // RULE_01
    if (is_host_spi(frame_ctrl))
    begin
      next_fmt.data_bits = 4'h8;
      next_fmt.spi_bit_order = frame_ctrl[usfc_pkg::SPI_ORDER_BIT]; // RULE_09
      next_fmt.spi_clock_phase = frame_ctrl[usfc_pkg::SPI_PHASE_BIT]; // RULE_11
    end
    else
    begin
      case (usfc_pkg::usfc_parity_type'(frame_ctrl[usfc_pkg::PARITY_HI:usfc_pkg::PARITY_LO]))
        usfc_pkg::PARITY_EVEN: next_fmt.parity_en = 1'b1; // RULE_04
        usfc_pkg::PARITY_ODD:
        begin
          next_fmt.parity_en = 1'b1; // RULE_04
          next_fmt.parity_odd = 1'b1;
        end
        usfc_pkg::PARITY_RSVD: next_fmt.parity_reserved = 1'b1; // RULE_04
        default: next_fmt.parity_en = 1'b0;
      endcase
      // Only the transmitter reads this; the receiver accepts any stop length.
      next_fmt.tx_stop_two = frame_ctrl[usfc_pkg::STOP_BIT]; // RULE_05 RULE_06
      next_fmt.data_bits = char_bits(frame_ctrl[usfc_pkg::SIZE_HI:usfc_pkg::SIZE_LO]); // RULE_07
      next_fmt.size_reserved =
        frame_ctrl[usfc_pkg::SIZE_HI:usfc_pkg::SIZE_LO] == 3'h4 ||
        frame_ctrl[usfc_pkg::SIZE_HI:usfc_pkg::SIZE_LO] == 3'h5; // RULE_07
      next_fmt.nine_bit_high_first =
        frame_ctrl[usfc_pkg::SIZE_HI:usfc_pkg::SIZE_LO] == 3'h7; // RULE_08
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fmt <= '0;
    end
    else
    begin
      fmt <= next_fmt;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rate_div_out <= usfc_pkg::RATE_DIV_RESET;
      ir_tx_pulse_len_out <= usfc_pkg::IR_TX_PULSE_RESET;
    end
    else
    begin
      rate_div_out <= rate_div;
      ir_tx_pulse_len_out <= ir_tx_pulse_len;
    end
  end

  // Halt applies one reference clock later in this domain; the link side sees it two link clocks later.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      periph_run <= 1'b1;
    end
    else
    begin
      periph_run <= !debug_halt || debug_ctrl[usfc_pkg::DEBUG_RUN_BIT]; // RULE_15
    end
  end

  // Events are dropped while halted with debug run at 0, and the control bit enables the input at 0.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ir_event_out <= 1'b0;
    end
    else
    begin
      ir_event_out <= ir_event_in && !event_ctrl[usfc_pkg::IR_EVENT_BIT] &&
                      periph_run; // RULE_16 RULE_15
    end
  end

  always_comb
  begin
    link_cfg.rate_div = rate_div;
    link_cfg.ir_tx_pulse_len = ir_tx_pulse_len;
    link_cfg.infrared_mode = frame_ctrl[usfc_pkg::LINK_MODE_HI:usfc_pkg::LINK_MODE_LO] ==
                             usfc_pkg::LINK_INFRARED; // RULE_18
    link_cfg.debug_run = debug_ctrl[usfc_pkg::DEBUG_RUN_BIT];
  end

  usfc_cfg_cross u_cross (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .load(cfg_load),
    .cfg_in(link_cfg),
    .busy(cross_busy),
    .link_clk(link_clk),
    .cfg_out(link_cfg_sync),
    .cfg_new(link_cfg_new)
  );

  usfc_link_rate u_rate (
    .link_clk(link_clk),
    .arst_n(arst_n),
    .cfg(link_cfg_sync),
    .cfg_new(link_cfg_new),
    .debug_halt_ref(debug_halt),
    .tx_level(tx_level),
    .rate_tick(rate_tick),
    .bit_start(bit_start),
    .ir_tx_out(ir_tx_out)
  );

endmodule // usfc_frame_config_regs

//--- tb/usfc_frame_config_regs_assertions.sv
// Port checker of the frame configuration block, bound to its top module.
`timescale 1ns/1ps
module usfc_checker (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // System
  input wire logic debug_halt,
  input wire logic ir_event_in,
  input wire logic ir_event_out,
  input wire logic periph_run,
  // Engine side
  input wire usfc_pkg::usfc_fmt_type fmt,
  input wire logic [15:0] rate_div_out,
  input wire logic rate_reload,
  input wire logic rate_tick,
  input wire logic bit_start
);
  logic [7:0] wd1;
  logic [7:0] wd2;
  // Write data two cycles back, so either decode latency is accepted.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wd1 <= 8'h00;
      wd2 <= 8'h00;
    end
    else
    begin
      wd1 <= reg_wdata;
      wd2 <= wd1;
    end
  end
  sequence fr_wr;
    reg_wr && reg_addr == usfc_pkg::OFS_FRAME_CTRL ##1 !reg_wr;
  endsequence
  AST_MP: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reg_wr && reg_addr == usfc_pkg::OFS_MODE_CTRL ##1 !reg_wr |=>
    fmt.multiproc_mode_en == wd2[0]) else $error("Multiprocessor decode wrong.");
  AST_MODE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fr_wr |=> fmt.link_mode_sel == wd2[7:6]) else $error("Link mode decode wrong.");
  AST_SPI_LAYOUT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fmt.link_mode_sel == usfc_pkg::LINK_HOST_SPI |-> !fmt.parity_en && !fmt.tx_stop_two
    && fmt.data_bits == 4'h8) else $error("Serial fields active in SPI mode.");
  AST_PARITY: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fr_wr |=> wd2[7:6] == 2'b11 || fmt.parity_en == wd2[5] && (!wd2[5] ||
    fmt.parity_odd == wd2[4])) else $error("Parity decode wrong.");
  AST_STOP: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fr_wr |=> wd2[7:6] == 2'b11 || fmt.tx_stop_two == wd2[3]) else $error("Stop decode wrong.");
  AST_SIZE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fr_wr |=> wd2[7:6] == 2'b11 || fmt.nine_bit_high_first == (wd2[2:0] == 3'h7) &&
    fmt.data_bits == (wd2[2:1] == 2'b11 ? 4'h9 : wd2[2] ? 4'h8 : 4'h5 + {2'b00, wd2[1:0]}))
    else $error("Size decode wrong.");
  AST_SPI_BITS: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fr_wr |=> wd2[7:6] != 2'b11 || fmt.spi_bit_order == wd2[2] &&
    fmt.spi_clock_phase == wd2[1]) else $error("SPI bit decode wrong.");
  AST_DIV_LO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reg_wr && reg_addr == usfc_pkg::OFS_RATE_DIV_LO |=> ##1
    rate_div_out[7:0] == $past(reg_wdata, 2)) else $error("Divisor low byte wrong.");
  AST_DIV_HI: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reg_wr && reg_addr == usfc_pkg::OFS_RATE_DIV_HI |=> ##1
    rate_div_out[15:8] == $past(reg_wdata, 2)) else $error("Divisor high byte wrong.");
  AST_RELOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reg_wr && reg_addr[3:1] == 3'b100 |=> rate_reload) else $error("No reload after write.");
  AST_RUN: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !debug_halt |=> periph_run) else $error("Stopped without halt.");
  AST_EVENT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ir_event_out |-> $past(ir_event_in) && $past(periph_run)) else $error("Stray event.");
  AST_BIT_TICK: assert property (@(posedge link_clk) disable iff (!arst_n)
    bit_start |-> rate_tick) else $error("Bit start off tick.");
  COV_DIV: cover property (@(posedge ref_clk) disable iff (!arst_n) rate_reload);
  COV_SPI: cover property (@(posedge ref_clk) disable iff (!arst_n)
    fmt.link_mode_sel == usfc_pkg::LINK_HOST_SPI);
  COV_HALT: cover property (@(posedge ref_clk) disable iff (!arst_n) debug_halt && !periph_run);
endmodule // usfc_checker

bind usfc_frame_config_regs usfc_checker usfc_checker_inst (.ref_clk, .link_clk, .arst_n,
  .reg_addr, .reg_wdata, .reg_wr, .debug_halt, .ir_event_in, .ir_event_out, .periph_run,
  .fmt, .rate_div_out, .rate_reload, .rate_tick, .bit_start);

//--- tb/usfc_link_partner.sv
// Link-side model that drives the transmit level and times the rate ticks.
`timescale 1ns/1ps
module usfc_link_partner (
  // Clock and reset
  input wire logic link_clk,
  input wire logic arst_n,
  // Link signals
  input wire logic rate_tick,
  input wire logic bit_start,
  output logic tx_level,
  // Measurement
  output logic [17:0] gap,
  output logic gap_new
);
  logic [17:0] cnt;
  // The level turns over at each bit start, so no bit repeats its neighbour.
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      tx_level <= 1'b1;
    else if (bit_start)
      tx_level <= ~tx_level;
  end
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 18'h1;
      gap <= 18'h0;
      gap_new <= 1'b0;
    end
    else
    begin
      cnt <= rate_tick ? 18'h1 : cnt + 18'h1;
      gap <= rate_tick ? cnt : gap;
      gap_new <= rate_tick;
    end
  end
endmodule // usfc_link_partner

//--- tb/usfc_frame_config_regs_bench.sv
// Self-checking bench of the frame configuration block with its link partner.
`timescale 1ns/1ps
module usfc_frame_config_regs_bench;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic debug_halt = 1'b0;
  logic ir_event_in = 1'b0;
  logic [7:0] reg_rdata;
  logic ir_event_out, periph_run, rate_reload, tx_level, rate_tick, bit_start, ir_tx_out, gap_new;
  usfc_pkg::usfc_fmt_type fmt;
  logic [15:0] rate_div_out;
  logic [15:0] d;
  logic [7:0] ir_tx_pulse_len_out;
  logic [7:0] v;
  logic [17:0] gap;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [3:0] ofs [7] = '{4'h7, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'ha};
  logic [7:0] rst [7] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int miscompares = 0;
  int checks_done = 0;

  always #5 ref_clk = ~ref_clk;
  always #3 link_clk = ~link_clk;

  usfc_frame_config_regs usfc_frame_config_regs_inst (.ref_clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .debug_halt, .ir_event_in, .ir_event_out,
    .periph_run, .fmt, .rate_div_out, .rate_reload, .ir_tx_pulse_len_out, .link_clk,
    .tx_level, .rate_tick, .bit_start, .ir_tx_out);
  usfc_link_partner usfc_link_partner_inst (.link_clk, .arst_n, .rate_tick, .bit_start,
    .tx_level, .gap, .gap_new);

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  always @(posedge ref_clk)
  begin
    rd_seen <= reg_rd;
    if (rd_seen)
      check({10'h0, reg_rdata}, {10'h0, exp_q.pop_front()});
  end

  initial
  begin
    #400000;
    miscompares++;
    complete_run;
  end

  initial
  begin
    void'($urandom(32'h4c2c_7493));
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], rst[i]);
    wr(4'ha, 8'hff);
    rd(4'ha, 8'h00);
    $display("reset values done");
    for (int m = 0; m < 4; m++)
    begin
      v = {m[1:0], 6'($urandom)};
      wr(4'h7, v);
      rd(4'h7, m == 3 ? v & 8'hc6 : v);
      settle();
      check(18'(fmt.link_mode_sel), 18'(m));
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(4'h7, 8'(c));
      settle();
      check(18'(fmt.data_bits), c > 5 ? 18'h9 : c > 3 ? 18'h8 : 18'(c + 5));
      check(18'(fmt.nine_bit_high_first), 18'(c == 7));
    end
    for (int p = 0; p < 4; p++)
    begin
      wr(4'h7, {2'b00, p[1:0], p[0], 3'b011});
      settle();
      check(18'(fmt.parity_en), 18'(p[1]));
      check(18'(fmt.parity_reserved), 18'(p == 1));
      check(18'(fmt.tx_stop_two), 18'(p[0]));
      wr(4'h7, {2'b11, 3'b000, p[1:0], 1'b0});
      settle();
      check(18'(fmt.spi_bit_order), 18'(p[1]));
      check(18'(fmt.spi_clock_phase), 18'(p[0]));
    end
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h01);
    settle();
    check(18'(fmt.multiproc_mode_en), 18'h1);
    $display("frame format done");
    // Divisor changes happen while the link partner keeps turning the level over at each bit start.
    d = 16'($urandom);
    wr(4'h8, d[7:0]);
    #1;
    check(18'(rate_reload), 18'h1);
    wr(4'h9, d[15:8]);
    settle();
    check(18'(rate_div_out), 18'(d));
    rd(4'h8, d[7:0]);
    rd(4'h9, d[15:8]);
    wr(4'h9, 8'h00);
    wr(4'h8, 8'h02);
    // Ticks of older divisors and the first gap after the reload are not a full period.
    repeat (20) @(posedge ref_clk);
    repeat (3) @(posedge link_clk iff gap_new);
    check(gap, 18'h3);
    @(posedge link_clk);
    v[0] = tx_level;
    #1;
    check(18'(ir_tx_out), 18'(v[0]));
    $display("rate divisor done");
    @(posedge ref_clk);
    debug_halt <= 1'b1;
    ir_event_in <= 1'b1;
    settle();
    check(18'(periph_run), 18'h0);
    check(18'(ir_event_out), 18'h0);
    wr(4'hb, 8'hff);
    rd(4'hb, 8'h01);
    settle();
    check(18'(periph_run), 18'h1);
    check(18'(ir_event_out), 18'h1);
    wr(4'hc, 8'hff);
    rd(4'hc, 8'h01);
    settle();
    check(18'(ir_event_out), 18'h0);
    @(posedge ref_clk);
    debug_halt <= 1'b0;
    $display("debug and event done");
    // The pulse length is set while the link partner still turns the transmit level over at each bit start.
    v = 8'($urandom);
    wr(4'hd, v);
    rd(4'hd, v);
    #1;
    check(18'(ir_tx_pulse_len_out), 18'(v));
    $display("pulse length done");
    repeat (3) @(posedge ref_clk);
    complete_run;
  end
endmodule // usfc_frame_config_regs_bench
